/* File: rtl/an_range_track.sv */
// Tracks lowest and highest autonegotiation state since the last restart.
// Assumes the state code is a synchronous 3-bit input.
`timescale 1ns/1ps
module an_range_track
    import qs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       restart,
    input  wire logic [2:0] state,
    output logic      [2:0] min_q,
    output logic      [2:0] max_q
);

    // ----------------------------------------------------------------
    // Range tracking
    // ----------------------------------------------------------------
    logic [2:0] min_d;
    logic [2:0] max_d;
    logic [2:0] min_run;
    logic [2:0] max_run;

    assign min_run = (state < min_q) ? state : min_q;
    assign max_run = (state > max_q) ? state : max_q;
    // Restart seeds with the present state so nothing is missed
    assign min_d   = restart ? state : min_run;
    assign max_d   = restart ? state : max_run;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            min_q <= RST_AN_MIN;
            max_q <= RST_AN_MAX;
        end else begin
            min_q <= min_d;
            max_q <= max_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_min_tracks: assert property (
        !restart |=> min_q <= $past(state) && min_q <= $past(min_q))
        else $error("lowest state not tracked");
    a_max_tracks: assert property (
        !restart |=> max_q >= $past(state) && max_q >= $past(max_q))
        else $error("highest state not tracked");
    a_restart_seed: assert property (
        restart |=> min_q == $past(state) && max_q == $past(state))
        else $error("range not reseeded on read");

endmodule

/* File: rtl/qs_pkg.sv */
// Constants and carrier types for the quick-status register block.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
package qs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0]  QS_ADDR       = 5'h1f;
    localparam logic [15:0] QS_RD_UNMAP   = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_RX_ERR   = 15;
    localparam int BIT_EVT14    = 14;
    localparam int BIT_REMOTE   = 13;
    localparam int BIT_UNLOCK   = 12;
    localparam int BIT_LINK     = 11;
    localparam int BIT_PAUSE    = 10;
    localparam int BIT_SPEED    = 9;
    localparam int BIT_DUPLEX   = 8;
    localparam int BIT_CFG      = 7;
    localparam int BIT_MASK     = 6;
    localparam int MIN_LSB      = 3;
    localparam int MAX_LSB      = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic       RST_FLAG   = 1'b0;
    localparam logic       RST_LINK   = 1'b0;
    localparam logic       RST_CFG    = 1'b0;
    localparam logic       RST_MASK   = 1'b0;
    localparam logic [2:0] RST_AN_MIN = 3'h7;
    localparam logic [2:0] RST_AN_MAX = 3'h0;

    // Sticky flag slots
    localparam int NFLAG   = 5;
    localparam int F_RXE   = 0;
    localparam int F_FC    = 1;
    localparam int F_LCH   = 2;
    localparam int F_RF    = 3;
    localparam int F_UJ    = 4;

    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic remote_fault;
        logic unlock;
        logic jabber;
    } phy_evt_t;

    typedef struct packed {
        logic       link_up;
        logic       fast_speed_ind;
        logic       duplex_ind;
        logic       pause_ind;
        logic [2:0] an_state;
    } phy_stat_t;

endpackage

/* File: rtl/quick_status.sv */
// Quick-status register of a 10/100 transceiver channel with its interrupt.
// Assumes the management frame logic presents decoded register strobes
// synchronous to clk, and that event inputs are one-cycle pulses.
`timescale 1ns/1ps
module quick_status
    import qs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic        mgmt_rd,
    input  wire logic        mgmt_wr,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_rvalid,
    input  wire phy_evt_t    evt,
    input  wire phy_stat_t   stat,
    output logic             irq_out
);

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    wire rd_hit;
    wire wr_hit;

    assign rd_hit = mgmt_rd && (mgmt_addr == QS_ADDR);
    assign wr_hit = mgmt_wr && (mgmt_addr == QS_ADDR);

    // ----------------------------------------------------------------
    // Writable configuration
    // ----------------------------------------------------------------
    logic cfg_q;
    logic cfg_d;
    logic mask_q;
    logic mask_d;

    assign cfg_d  = wr_hit ? mgmt_wdata[BIT_CFG]  : cfg_q;
    assign mask_d = wr_hit ? mgmt_wdata[BIT_MASK] : mask_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_q  <= RST_CFG;
            mask_q <= RST_MASK;
        end else begin
            cfg_q  <= cfg_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Latching-low link status
    // ----------------------------------------------------------------
    logic link_valid_q;
    logic link_valid_d;

    // A read reloads from the live link, so a failure in that cycle stays
    assign link_valid_d = rd_hit ? stat.link_up
                                 : (link_valid_q & stat.link_up);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            link_valid_q <= RST_LINK;
        end else begin
            link_valid_q <= link_valid_d;
        end
    end

    // ----------------------------------------------------------------
    // Sticky event flags
    // ----------------------------------------------------------------
    wire              fast;
    wire [NFLAG-1:0]  flag_set;
    wire [NFLAG-1:0]  flags;

    assign fast = stat.fast_speed_ind;
    // Receive-side errors only count at 100M
    assign flag_set[F_RXE] = evt.rx_error & fast;
    assign flag_set[F_FC]  = evt.false_carrier & fast;
    assign flag_set[F_LCH] = link_valid_d ^ link_valid_q;
    assign flag_set[F_RF]  = evt.remote_fault;
    assign flag_set[F_UJ]  = fast ? evt.unlock : evt.jabber;

    // Read strobe clears after the snapshot is taken on the same edge
    sticky_flags #(
        .W (NFLAG)
    ) u_flags (
        .clk  (clk),
        .rstn (rstn),
        .set  (flag_set),
        .clr  (rd_hit),
        .q    (flags)
    );

    // ----------------------------------------------------------------
    // Autonegotiation state range
    // ----------------------------------------------------------------
    wire [2:0] an_state_min;
    wire [2:0] an_state_max;

    an_range_track u_an (
        .clk     (clk),
        .rstn    (rstn),
        .restart (rd_hit),
        .state   (stat.an_state),
        .min_q   (an_state_min),
        .max_q   (an_state_max)
    );

    // ----------------------------------------------------------------
    // Register image
    // ----------------------------------------------------------------
    wire        bit14;
    wire [15:0] qs_value;

    // Both flags run all the time; the select only picks which shows
    assign bit14 = cfg_q ? flags[F_LCH] : flags[F_FC];

    assign qs_value[BIT_RX_ERR]  = flags[F_RXE];
    assign qs_value[BIT_EVT14]   = bit14;
    assign qs_value[BIT_REMOTE]  = flags[F_RF];
    assign qs_value[BIT_UNLOCK]  = flags[F_UJ];
    assign qs_value[BIT_LINK]    = link_valid_q;
    assign qs_value[BIT_PAUSE]   = stat.pause_ind;
    assign qs_value[BIT_SPEED]   = stat.fast_speed_ind;
    assign qs_value[BIT_DUPLEX]  = stat.duplex_ind;
    assign qs_value[BIT_CFG]     = cfg_q;
    assign qs_value[BIT_MASK]    = mask_q;
    assign qs_value[MIN_LSB+:3]  = an_state_min;
    assign qs_value[MAX_LSB+:3]  = an_state_max;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [15:0] rdata_d;

    // Other addresses belong to neighbouring blocks; answer zero here
    assign rdata_d = rd_hit ? qs_value : QS_RD_UNMAP;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mgmt_rdata  <= QS_RD_UNMAP;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd) begin
                mgmt_rdata <= rdata_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    wire any_evt;
    wire irq_src;
    wire irq_d;

    assign any_evt = flags[F_RXE] | bit14 | flags[F_RF] | flags[F_UJ]
                   | ~link_valid_q;
    assign irq_src = cfg_q ? flags[F_LCH] : any_evt;
    // Level follows the latched flags, so a read is what drops it
    assign irq_d   = ~mask_q & irq_src;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_read;
        rd_hit;
    endsequence

    sequence s_answer(logic [15:0] v);
        mgmt_rvalid && (mgmt_rdata == v);
    endsequence

    // Set, then held unless the previous cycle was a clearing read
    sequence s_kept(logic f);
        f ##1 (f || $past(rd_hit));
    endsequence

    a_read_answer: assert property (
        s_read |=> s_answer($past(qs_value)))
        else $error("read did not return register image");
    a_rx_latch: assert property (
        evt.rx_error && fast |=> s_kept(flags[F_RXE]))
        else $error("receive error not latched");
    a_rx_slow: assert property (
        !flags[F_RXE] && !fast && !rd_hit |=> !flags[F_RXE])
        else $error("receive error latched at 10M");
    a_remote_hold: assert property (
        flags[F_RF] && !rd_hit |=> flags[F_RF])
        else $error("remote fault dropped without read");
    a_jabber_slow: assert property (
        !fast && evt.jabber |=> flags[F_UJ])
        else $error("jabber not latched at 10M");
    a_link_low: assert property (
        !stat.link_up |=> !link_valid_q ##1 (!link_valid_q || $past(rd_hit)))
        else $error("link failure not latched low");
    a_link_change: assert property (
        cfg_q && $changed(link_valid_q) |-> flags[F_LCH] && bit14)
        else $error("link change not flagged");
    a_speed_read: assert property (
        s_read |=> mgmt_rdata[BIT_SPEED] == $past(stat.fast_speed_ind))
        else $error("speed bit wrong");
    a_irq_mask: assert property (
        mask_q |=> !irq_out)
        else $error("masked channel raised interrupt");
    a_irq_cfg0: assert property (
        !mask_q && !cfg_q && !link_valid_q |=> irq_out)
        else $error("link low did not interrupt");
    a_irq_cfg1: assert property (
        !mask_q && cfg_q |=> irq_out == $past(flags[F_LCH]))
        else $error("config one interrupt source wrong");

    // ----------------------------------------------------------------
    // Flag checks
    // ----------------------------------------------------------------
    a_fc_latch: assert property (
        evt.false_carrier && fast |=> s_kept(flags[F_FC]))
        else $error("false carrier not latched");
    a_fc_slow: assert property (
        !flags[F_FC] && !fast && !rd_hit |=> !flags[F_FC])
        else $error("false carrier latched at 10M");
    a_remote_latch: assert property (
        evt.remote_fault |=> s_kept(flags[F_RF]))
        else $error("remote fault not latched");
    a_unlock_fast: assert property (
        fast && evt.unlock |=> flags[F_UJ])
        else $error("unlock not latched at 100M");
    a_unlock_slow: assert property (
        !flags[F_UJ] && !fast && !evt.jabber && !rd_hit |=> !flags[F_UJ])
        else $error("unlock latched at 10M");
    a_jabber_fast: assert property (
        !flags[F_UJ] && fast && !evt.unlock && !rd_hit |=> !flags[F_UJ])
        else $error("jabber latched at 100M");
    a_read_clears: assert property (
        rd_hit && !evt.remote_fault |=> !flags[F_RF])
        else $error("remote fault survived its read");

    // ----------------------------------------------------------------
    // Link, read and write checks
    // ----------------------------------------------------------------
    a_link_hold: assert property (
        !link_valid_q && !rd_hit |=> !link_valid_q)
        else $error("link bit rose without a read");
    a_link_reload: assert property (
        s_read |=> link_valid_q == $past(stat.link_up))
        else $error("link bit not reloaded by read");
    a_pause_read: assert property (
        s_read |=> mgmt_rdata[BIT_PAUSE] == $past(stat.pause_ind))
        else $error("pause bit wrong");
    a_duplex_read: assert property (
        s_read |=> mgmt_rdata[BIT_DUPLEX] == $past(stat.duplex_ind))
        else $error("duplex bit wrong");
    a_rvalid_set: assert property (
        mgmt_rd |=> mgmt_rvalid)
        else $error("read not answered");
    a_rvalid_pulse: assert property (
        !mgmt_rd |=> !mgmt_rvalid)
        else $error("answer without a read");
    a_cfg_write: assert property (
        wr_hit |=> cfg_q == $past(mgmt_wdata[BIT_CFG])
                && mask_q == $past(mgmt_wdata[BIT_MASK]))
        else $error("configuration write lost");

    // ----------------------------------------------------------------
    // Interrupt checks
    // ----------------------------------------------------------------
    a_irq_flags: assert property (
        !mask_q && !cfg_q
        && (flags[F_RXE] || flags[F_FC] || flags[F_RF] || flags[F_UJ])
        |=> irq_out)
        else $error("latched event did not interrupt");
    a_irq_quiet: assert property (
        !mask_q && !cfg_q && link_valid_q
        && !(flags[F_RXE] || flags[F_FC] || flags[F_RF] || flags[F_UJ])
        |=> !irq_out)
        else $error("interrupt without a cause");
    a_irq_cfg1_lch: assert property (
        cfg_q && !flags[F_LCH] |=> !irq_out)
        else $error("config one interrupt from other source");

endmodule

/* File: rtl/sticky_flags.sv */
// Bank of sticky event flags cleared by a single strobe.
// Assumes set and clear are synchronous to clk; set wins over clear.
`timescale 1ns/1ps
module sticky_flags
    import qs_pkg::*;
#(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output logic      [W-1:0] q
);

    // ----------------------------------------------------------------
    // Flag storage
    // ----------------------------------------------------------------
    logic [W-1:0] q_d;

    // An event in the clearing cycle survives for the next read
    assign q_d = set | (q & ~{W{clr}});

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= {W{RST_FLAG}};
        end else begin
            q <= q_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_set_wins: assert property (set[0] && clr |=> q[0])
        else $error("flag lost on coincident clear");
    a_flag_cleared: assert property (clr && !set[0] |=> !q[0])
        else $error("flag not cleared after read");

endmodule

/* File: test/mgmt_host.sv */
// Management host model issuing reads and writes as strobes.
// Assumes the bench calls its tasks; strobes move at falling edges.
`timescale 1ns/1ps
module mgmt_host (
    input  wire logic        clk,
    output logic      [4:0]  mgmt_addr,
    output logic             mgmt_rd,
    output logic             mgmt_wr,
    output logic      [15:0] mgmt_wdata,
    input  wire logic [15:0] mgmt_rdata,
    input  wire logic        mgmt_rvalid
);
    initial begin
        mgmt_addr  = 5'h00;
        mgmt_rd    = 1'b0;
        mgmt_wr    = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    // Released lines show the inverse so stale values never match
    task automatic rd(input logic [4:0] a, output logic [15:0] d,
                      output logic ok);
        @(negedge clk);
        mgmt_addr = a;
        mgmt_rd   = 1'b1;
        @(negedge clk);
        mgmt_rd   = 1'b0;
        mgmt_addr = ~a;
        ok = mgmt_rvalid;
        d  = mgmt_rdata;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        mgmt_addr  = a;
        mgmt_wdata = d;
        mgmt_wr    = 1'b1;
        @(negedge clk);
        mgmt_wr    = 1'b0;
        mgmt_addr  = ~a;
        mgmt_wdata = ~d;
    endtask
endmodule

/* File: test/test_quick_status.sv */
// Self-checking bench for the quick-status register and interrupt.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ps
module test_quick_status
    import qs_pkg::*;
;
    logic        clk;
    logic        rstn;
    logic [4:0]  mgmt_addr;
    logic        mgmt_rd;
    logic        mgmt_wr;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic        mgmt_rvalid;
    phy_evt_t    evt;
    phy_stat_t   stat;
    logic        irq_out;
    int          err_total;
    int          samples_checked;
    int          cycles = 0;
    logic [15:0] d;
    logic        ok;

    quick_status quick_status_i (.clk(clk), .rstn(rstn),
        .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .evt(evt), .stat(stat),
        .irq_out(irq_out));
    mgmt_host mgmt_host_i (.clk(clk), .mgmt_addr(mgmt_addr),
        .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    // ----------------------------------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp16({15'h0, g}, {15'h0, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Min and max are 3 because an_state is held at 3
    function automatic logic [15:0] img(logic ln, logic c, logic m);
        return {4'h0, ln, stat.pause_ind, stat.fast_speed_ind,
                stat.duplex_ind, c, m, 3'h3, 3'h3};
    endfunction
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        mgmt_host_i.rd(a, d, ok);
        cmp1(ok, 1'b1);
        cmp16(d, e);
    endtask
    task automatic pulse(input phy_evt_t e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        idle(2);
        cmp1(irq_out, 1'b1);
        rdc(QS_ADDR, img(1'b0, 1'b0, 1'b0));
        rdc(QS_ADDR, img(1'b1, 1'b0, 1'b0));
        idle(2);
        cmp1(irq_out, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_events();
        logic [4:0]  ev [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h10};
        logic [15:0] ex [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                16'h1000, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            stat.fast_speed_ind = (i < 4);
            pulse(ev[i]);
            idle(2);
            cmp1(irq_out, ex[i] != 0);
            rdc(QS_ADDR, ex[i] | img(1'b1, 1'b0, 1'b0));
            rdc(QS_ADDR, img(1'b1, 1'b0, 1'b0));
            idle(2);
            cmp1(irq_out, 1'b0);
        end
        stat.fast_speed_ind = 1'b1;
        fork
            mgmt_host_i.rd(QS_ADDR, d, ok);
            pulse(5'h10);
        join
        cmp16(d, img(1'b1, 1'b0, 1'b0));
        rdc(QS_ADDR, 16'h8000 | img(1'b1, 1'b0, 1'b0));
        $display("test events done");
    endtask
    task automatic t_cfg();
        mgmt_host_i.wr(QS_ADDR, 16'h0080);
        pulse(5'h08);
        idle(2);
        cmp1(irq_out, 1'b0);
        @(negedge clk);
        stat.link_up = 1'b0;
        @(negedge clk);
        stat.link_up = 1'b1;
        idle(2);
        cmp1(irq_out, 1'b1);
        rdc(QS_ADDR, 16'h4000 | img(1'b0, 1'b1, 1'b0));
        rdc(QS_ADDR, 16'h4000 | img(1'b1, 1'b1, 1'b0));
        rdc(QS_ADDR, img(1'b1, 1'b1, 1'b0));
        mgmt_host_i.wr(QS_ADDR, 16'h0040);
        pulse(5'h10);
        idle(2);
        cmp1(irq_out, 1'b0);
        rdc(QS_ADDR, 16'h8000 | img(1'b1, 1'b0, 1'b1));
        mgmt_host_i.wr(QS_ADDR, 16'h0000);
        $display("test config done");
    endtask
    task automatic t_map();
        stat.pause_ind  = 1'b0;
        stat.duplex_ind = 1'b0;
        mgmt_host_i.wr(5'h00, 16'h00c0);
        rdc(5'h10, QS_RD_UNMAP);
        rdc(QS_ADDR, img(1'b1, 1'b0, 1'b0));
        stat.fast_speed_ind = 1'b0;
        idle(1);
        rdc(QS_ADDR, img(1'b1, 1'b0, 1'b0));
        $display("test map done");
    endtask
    task automatic t_an();
        int seq [3] = '{1, 6, 2};
        stat.an_state = 3'h5;
        mgmt_host_i.rd(QS_ADDR, d, ok);
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            stat.an_state = seq[i][2:0];
        end
        rdc(QS_ADDR, {img(1'b1, 1'b0, 1'b0)} & 16'hffc0 | 16'h000e);
        $display("test autoneg done");
    endtask

    initial begin
        rstn = 1'b0;
        evt  = '0;
        stat = '{link_up: 1'b1, fast_speed_ind: 1'b1, duplex_ind: 1'b1,
                 pause_ind: 1'b1, an_state: 3'h3};
        err_total = 0;
        samples_checked = 0;
        idle(6);
        rstn = 1'b1;
        t_reset();
        t_events();
        t_cfg();
        t_map();
        t_an();
        end_of_test();
    end
endmodule
